// >>> rtl/dpwm_map.svh
// Register map, field positions and timing constants for the dual timer-based PWM block
`ifndef DPWM_MAP_SVH
`define DPWM_MAP_SVH
`define DPWM_ADDR_W        4
`define DPWM_OFF_DUTY1_HI  4'h0
`define DPWM_OFF_DUTY1_LO  4'h1
`define DPWM_OFF_DUTY2_HI  4'h2
`define DPWM_OFF_DUTY2_LO  4'h3
`define DPWM_OFF_PERIOD1   4'h4
`define DPWM_OFF_PERIOD2   4'h5
`define DPWM_OFF_CTRL      4'h6
`define DPWM_OFF_COUNT1    4'h7
`define DPWM_OFF_COUNT2    4'h8
`define DPWM_OFF_IRQ_STAT  4'h9
`define DPWM_OFF_IRQ_EN    4'ha
`define DPWM_OFF_IRQ_CLR   4'hb
`define DPWM_SEL_BIT       5
`define DPWM_LOW_MSB       7
`define DPWM_LOW_LSB       6
`define DPWM_CTRL_RUN1     0
`define DPWM_CTRL_RUN2     1
`define DPWM_CTRL_OUT1     2
`define DPWM_CTRL_OUT2     3
`define DPWM_CTRL_CHAIN    4
`define DPWM_PERIOD_RST    8'hff
`define DPWM_QUARTERS      4
`endif

// >>> rtl/dpwm_pkg.sv
// Types shared by the dual PWM block
package dpwm_pkg;
    typedef logic [7:0] dpwm_byte_t;
    typedef logic [9:0] dpwm_duty_t;
endpackage

// >>> rtl/dpwm_chan.sv
// One PWM channel: double-buffered duty latches and output compare
`include "dpwm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dpwm_chan (
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 en_i,
    input  wire logic                 load_i,
    input  wire logic                 enable_i,
    input  wire logic [9:0]           fine_i,
    input  wire logic                 wr_hi_i,
    input  wire logic                 wr_lo_i,
    input  wire dpwm_pkg::dpwm_byte_t wdata_i,
    output logic [7:0]                act_hi_o,
    output logic [7:0]                act_lo_o,
    output logic                      pin_o
);
    import dpwm_pkg::*;
    dpwm_byte_t m_hi_reg;
    dpwm_byte_t m_lo_reg;
    dpwm_byte_t s_hi_reg;
    dpwm_byte_t s_lo_reg;
    logic       pin_reg;
    dpwm_duty_t duty_w;
    wire        reach_w;

    assign duty_w   = {s_hi_reg, s_lo_reg[`DPWM_LOW_MSB:`DPWM_LOW_LSB]};
    // The pin register lags by one clock, so the drop is judged on the count one step ahead
    assign reach_w  = (({1'b0, fine_i} + 11'h001) >= {1'b0, duty_w});
    assign act_hi_o = s_hi_reg;
    assign act_lo_o = s_lo_reg;
    assign pin_o    = pin_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            m_hi_reg <= 8'h00;
            m_lo_reg <= 8'h00;
        end else if (en_i) begin
            if (wr_hi_i) m_hi_reg <= wdata_i;
            if (wr_lo_i) m_lo_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_hi_reg <= 8'h00;
            s_lo_reg <= 8'h00;
            pin_reg  <= 1'b0;
        end else if (en_i) begin
            if (!enable_i) begin
                pin_reg <= 1'b0;
            end else if (load_i) begin
                s_hi_reg <= m_hi_reg;
                s_lo_reg <= m_lo_reg;
                // Duty of zero never rises, so the copy is judged on the incoming value
                pin_reg  <= ({m_hi_reg, m_lo_reg[`DPWM_LOW_MSB:`DPWM_LOW_LSB]} != 10'h000);
            end else if (reach_w) begin
                pin_reg <= 1'b0;
            end
        end
    end

    a_zero_duty_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (en_i && enable_i && !load_i && duty_w == 10'h000) |=> !pin_reg)
        else $error("output high with zero duty");
endmodule
`default_nettype wire

// >>> rtl/dpwm_top.sv
// Dual timer-based PWM generator with register port and match interrupt
`include "dpwm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dpwm_top (
    input  wire logic                     clk_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     clk_en_i,
    input  wire logic [`DPWM_ADDR_W-1:0]  addr_i,
    input  wire dpwm_pkg::dpwm_byte_t     wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output dpwm_pkg::dpwm_byte_t          rdata_o,
    output logic                          pulse_out_one_o,
    output logic                          pulse_out_two_o,
    output logic                          irq_o
);
    import dpwm_pkg::*;

    // Each timebase count lasts four oscillator periods; here one clock is one quarter
    dpwm_byte_t period_limit_one_reg;
    dpwm_byte_t period_limit_two_reg;
    dpwm_byte_t timebase_one_count_reg;
    dpwm_byte_t timebase_two_count_reg;
    logic [1:0] q1_reg;
    logic [1:0] q2_reg;
    logic [4:0] ctrl_reg;
    logic [1:0] stat_reg;
    logic [1:0] irq_en_reg;
    dpwm_byte_t rdata_reg;
    logic       irq_reg;
    logic       p1_reg;
    logic       p2_reg;

    wire        run1_w  = ctrl_reg[`DPWM_CTRL_RUN1];
    wire        run2_w  = ctrl_reg[`DPWM_CTRL_RUN2];
    wire        out1_w  = ctrl_reg[`DPWM_CTRL_OUT1];
    wire        out2_w  = ctrl_reg[`DPWM_CTRL_OUT2];
    // Chaining is only honoured when neither output is in use
    wire        chain_w = ctrl_reg[`DPWM_CTRL_CHAIN] && !out1_w && !out2_w;

    wire        sel_w;
    wire        last_q1_w = (q1_reg == 2'h3);
    wire        last_q2_w = (q2_reg == 2'h3);
    wire        match1_w  = run1_w && last_q1_w && !chain_w
                            && (timebase_one_count_reg == period_limit_one_reg);
    wire        tick2_w   = chain_w ? (last_q1_w && run1_w && timebase_one_count_reg == 8'hff)
                                    : (run2_w && last_q2_w);
    wire        match2_w  = tick2_w && (timebase_two_count_reg == period_limit_two_reg);
    // When chained, timebase one wraps at 0xff by its own increment
    wire        roll1_w   = match1_w;

    wire [9:0]  fine1_w = {timebase_one_count_reg, q1_reg};
    wire [9:0]  fine2_w = {timebase_two_count_reg, q2_reg};
    wire        load2_w = sel_w ? match2_w : match1_w;
    wire [9:0]  fine_two_w = sel_w ? fine2_w : fine1_w;

    wire        wr_d1h_w  = wr_i && addr_i == `DPWM_OFF_DUTY1_HI;
    wire        wr_d1l_w  = wr_i && addr_i == `DPWM_OFF_DUTY1_LO;
    wire        wr_d2h_w  = wr_i && addr_i == `DPWM_OFF_DUTY2_HI;
    wire        wr_d2l_w  = wr_i && addr_i == `DPWM_OFF_DUTY2_LO;
    wire        wr_pr1_w  = wr_i && addr_i == `DPWM_OFF_PERIOD1;
    wire        wr_pr2_w  = wr_i && addr_i == `DPWM_OFF_PERIOD2;
    wire        wr_ctl_w  = wr_i && addr_i == `DPWM_OFF_CTRL;
    wire        wr_ien_w  = wr_i && addr_i == `DPWM_OFF_IRQ_EN;
    wire        wr_clr_w  = wr_i && addr_i == `DPWM_OFF_IRQ_CLR;
    wire [1:0]  clr_w     = wr_clr_w ? wdata_i[1:0] : 2'b00;
    wire [1:0]  set_w     = {match2_w, match1_w};

    wire [7:0]  a1h_w;
    wire [7:0]  a1l_w;
    wire [7:0]  a2h_w;
    wire [7:0]  a2l_w;
    wire        pin1_w;
    wire        pin2_w;

    // Select bit lives in output two's slave low latch, taking effect at its next load
    assign sel_w = a2l_w[`DPWM_SEL_BIT];

    dpwm_chan u_chan_one (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .en_i     (clk_en_i),
        .load_i   (match1_w),
        .enable_i (out1_w),
        .fine_i   (fine1_w),
        .wr_hi_i  (wr_d1h_w),
        .wr_lo_i  (wr_d1l_w),
        .wdata_i  (wdata_i),
        .act_hi_o (a1h_w),
        .act_lo_o (a1l_w),
        .pin_o    (pin1_w)
    );

    dpwm_chan u_chan_two (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .en_i     (clk_en_i),
        .load_i   (load2_w),
        .enable_i (out2_w),
        .fine_i   (fine_two_w),
        .wr_hi_i  (wr_d2h_w),
        .wr_lo_i  (wr_d2l_w),
        .wdata_i  (wdata_i),
        .act_hi_o (a2h_w),
        .act_lo_o (a2l_w),
        .pin_o    (pin2_w)
    );

    // Read mux shows slave latches for duty registers, not what was last written
    dpwm_byte_t rd_mux_w;
    assign rd_mux_w =
        (addr_i == `DPWM_OFF_DUTY1_HI) ? a1h_w :
        (addr_i == `DPWM_OFF_DUTY1_LO) ? a1l_w :
        (addr_i == `DPWM_OFF_DUTY2_HI) ? a2h_w :
        (addr_i == `DPWM_OFF_DUTY2_LO) ? a2l_w :
        (addr_i == `DPWM_OFF_PERIOD1)  ? period_limit_one_reg :
        (addr_i == `DPWM_OFF_PERIOD2)  ? period_limit_two_reg :
        (addr_i == `DPWM_OFF_CTRL)     ? {3'h0, ctrl_reg} :
        (addr_i == `DPWM_OFF_COUNT1)   ? timebase_one_count_reg :
        (addr_i == `DPWM_OFF_COUNT2)   ? timebase_two_count_reg :
        (addr_i == `DPWM_OFF_IRQ_STAT) ? {6'h00, stat_reg} :
        (addr_i == `DPWM_OFF_IRQ_EN)   ? {6'h00, irq_en_reg} :
                                         8'h00;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period_limit_one_reg <= `DPWM_PERIOD_RST;
            period_limit_two_reg <= `DPWM_PERIOD_RST;
            ctrl_reg             <= 5'h00;
            irq_en_reg           <= 2'b00;
        end else if (clk_en_i) begin
            if (wr_pr1_w) period_limit_one_reg <= wdata_i;
            if (wr_pr2_w) period_limit_two_reg <= wdata_i;
            if (wr_ctl_w) ctrl_reg <= wdata_i[4:0];
            if (wr_ien_w) irq_en_reg <= wdata_i[1:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q1_reg                 <= 2'h0;
            timebase_one_count_reg <= 8'h00;
        end else if (clk_en_i && run1_w) begin
            q1_reg <= q1_reg + 2'h1;
            if (roll1_w) timebase_one_count_reg <= 8'h00;
            else if (last_q1_w) timebase_one_count_reg <= timebase_one_count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q2_reg                 <= 2'h0;
            timebase_two_count_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (run2_w && !chain_w) q2_reg <= q2_reg + 2'h1;
            if (match2_w) timebase_two_count_reg <= 8'h00;
            else if (tick2_w) timebase_two_count_reg <= timebase_two_count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_reg  <= 2'b00;
            rdata_reg <= 8'h00;
            irq_reg   <= 1'b0;
            p1_reg    <= 1'b0;
            p2_reg    <= 1'b0;
        end else if (clk_en_i) begin
            stat_reg  <= (stat_reg & ~clr_w) | set_w;
            rdata_reg <= rd_i ? rd_mux_w : 8'h00;
            irq_reg   <= |(((stat_reg & ~clr_w) | set_w) & irq_en_reg);
            p1_reg    <= pin1_w;
            p2_reg    <= pin2_w;
        end
    end

    assign rdata_o         = rdata_reg;
    assign irq_o           = irq_reg;
    assign pulse_out_one_o = p1_reg;
    assign pulse_out_two_o = p2_reg;

    // Helper: clocks since the last timebase one match; holds the period length minus one at the next match
    logic [10:0] per_cnt_reg;
    logic        per_seen_reg;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            per_cnt_reg  <= 11'h000;
            per_seen_reg <= 1'b0;
        end else if (clk_en_i) begin
            per_cnt_reg  <= match1_w ? 11'h000 : per_cnt_reg + 11'h001;
            if (match1_w) per_seen_reg <= 1'b1;
            if (wr_pr1_w || wr_ctl_w || !run1_w) per_seen_reg <= 1'b0;
        end
    end

    sequence s_match_one;
        clk_en_i && match1_w;
    endsequence

    a_period_len: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_match_one ##0 per_seen_reg) |-> per_cnt_reg == ({3'h0, period_limit_one_reg} * 11'd4 + 11'd3))
        else $error("period length differs from limit plus one times four");
    a_count_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_match_one |=> timebase_one_count_reg == 8'h00)
        else $error("timebase one not cleared after match");
    a_flag_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_match_one |=> stat_reg[0])
        else $error("match flag one not set");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && stat_reg[0] && !clr_w[0]) |=> stat_reg[0])
        else $error("match flag one cleared without software");
    a_pin_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_match_one ##0 (out1_w && {u_chan_one.m_hi_reg, u_chan_one.m_lo_reg[7:6]} != 10'h000))
        |=> ##1 pulse_out_one_o)
        else $error("output one not driven high at new period");
    a_full_duty: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && out1_w && run1_w && pin1_w && a1h_w > period_limit_one_reg) |=> pin1_w)
        else $error("output one dropped with duty above period");
    a_no_chain: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (out1_w || out2_w) |-> !chain_w)
        else $error("timebases chained while an output is in use");
    a_sel_base: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!sel_w && match1_w && out2_w && clk_en_i && !(u_chan_two.m_hi_reg == 8'h00
         && u_chan_two.m_lo_reg[7:6] == 2'b00)) |=> pin2_w)
        else $error("output two did not follow timebase one");
    a_read_slave: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && rd_i && addr_i == `DPWM_OFF_DUTY1_HI) |=> rdata_o == $past(a1h_w))
        else $error("duty read did not return slave latch");
    a_low_at_duty: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && out1_w && !match1_w && ({1'b0, fine1_w} + 11'h001) >= {1'b0, a1h_w, a1l_w[7:6]})
        |=> !pin1_w)
        else $error("output one high past duty");
    a_reset_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !out1_w |=> ##1 !pulse_out_one_o)
        else $error("output one high while disabled");
    // follow from the latch and counter structure
endmodule
`default_nettype wire

// >>> tb/dpwm_load.sv
// Load model on one PWM pin: counts high cycles and rising edges over a window
`timescale 1ns/1ps
`default_nettype none
module dpwm_load (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        pin_i,
    input  wire logic        clr_i,
    output logic [15:0]      high_o,
    output logic [15:0]      rise_o
);
    logic pin_reg;

    // The previous level keeps tracking through a clear, so no rise is lost at the window edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_reg <= 1'b0;
            high_o  <= 16'h0000;
            rise_o  <= 16'h0000;
        end else begin
            pin_reg <= pin_i;
            if (clr_i) begin
                high_o <= 16'h0000;
                rise_o <= 16'h0000;
            end else begin
                high_o <= high_o + {15'h0000, pin_i};
                rise_o <= rise_o + {15'h0000, pin_i & ~pin_reg};
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the dual PWM block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpwm_pkg::*;
    logic        clk_i    = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [3:0]  addr_i   = 4'h0;
    dpwm_byte_t  wdata_i  = 8'h00;
    logic        wr_i     = 1'b0;
    logic        rd_i     = 1'b0;
    logic        clr      = 1'b0;
    dpwm_byte_t  rdata_o;
    logic        pout1;
    logic        pout2;
    logic        irq_o;
    logic [15:0] hi1;
    logic [15:0] ed1;
    logic [15:0] hi2;
    logic [15:0] ed2;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles   = 0;

    always #2 clk_i = ~clk_i;

    dpwm_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
                    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pulse_out_one_o(pout1),
                    .pulse_out_two_o(pout2), .irq_o(irq_o));
    dpwm_load i_load1 (.clk_i(clk_i), .arst_n_i(arst_n_i), .pin_i(pout1), .clr_i(clr), .high_o(hi1), .rise_o(ed1));
    dpwm_load i_load2 (.clk_i(clk_i), .arst_n_i(arst_n_i), .pin_i(pout2), .clr_i(clr), .high_o(hi2), .rise_o(ed2));

    task automatic close_out;
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Software never read-modify-writes a duty register: every write is a fresh value
    task automatic wr(input logic [3:0] a, input dpwm_byte_t d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input dpwm_byte_t exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // Window of 32 cycles: a whole number of periods for both limits used here
    task automatic measure;
        repeat (20) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (32) @(posedge clk_i);
        #1;
    endtask

    task automatic duty1(input dpwm_byte_t h, input dpwm_byte_t l, input logic [15:0] eh, input logic [15:0] ee);
        wr(4'h0, h);
        wr(4'h1, l);
        measure();
        chk(hi1, eh);
        chk(ed1, ee);
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h3, 8'h00);
        rd_chk(4'h4, 8'hff);
        rd_chk(4'hf, 8'h00);
        chk({pout1, pout2}, 16'h0000);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h01);
        wr(4'h0, 8'h01);
        rd_chk(4'h0, 8'h00);
        wr(4'h6, 8'h0f);
        duty1(8'h00, 8'h00, 16'd0, 16'd0);
        duty1(8'h01, 8'h80, 16'd12, 16'd2);
        duty1(8'h03, 8'h40, 16'd26, 16'd2);
        duty1(8'h03, 8'hc0, 16'd30, 16'd2);
        duty1(8'h04, 8'h00, 16'd32, 16'd0);
        rd_chk(4'h0, 8'h04);
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h20);
        measure();
        chk(hi2, 16'd16);
        chk(ed2, 16'd4);
        rd_chk(4'h3, 8'h20);
        wr(4'h3, 8'h00);
        measure();
        chk(hi2, 16'd8);
        chk(ed2, 16'd2);
        rd_chk(4'h9, 8'h03);
        wr(4'h6, 8'h0c);
        wr(4'hb, 8'h03);
        rd_chk(4'h9, 8'h00);
        rd_chk(4'hb, 8'h00);
        wr(4'ha, 8'h01);
        repeat (3) @(posedge clk_i);
        #1;
        chk(irq_o, 16'h0000);
        wr(4'h6, 8'h0d);
        repeat (20) @(posedge clk_i);
        #1;
        chk(irq_o, 16'h0001);
        wr(4'h6, 8'h0c);
        wr(4'h9, 8'h00);
        rd_chk(4'h9, 8'h01);
        wr(4'ha, 8'h00);
        repeat (3) @(posedge clk_i);
        #1;
        chk(irq_o, 16'h0000);
        close_out();
    end
endmodule
`default_nettype wire
